// ==== fupd_cmd_frame.sv ====
// flash update / read-from-flash command frame handler: header check, payload
// checksum, flash target selection and 64-byte response generation
// assumes byte streams, flash port and register bus all run on core_clk
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "fupd_params.svh"

// Functional notes
// - every header starts at offset zero with the marker a1ec, high byte first.
// - byte two of each header holds protocol revision three, sent and checked.
// - the command byte picks the flash target, one distinct code per target.
// - the length field at offset eight, high byte first, counts the payload bytes.
// - the payload follows the header at offset 0x40 as a plain byte stream.
// - the payload checksum at 0x3a is a crc-32 over the payload, compared on receipt unless the skip flag, bit 0 of the flags, is set.
// - the header checksum at 0x3e is crc-ccitt from zero over bytes 2 to 0x3d.
// - subcommand and target offset fields are not used to steer the update.
// - an update response has zero length, zero payload checksum and no payload.
// - code 8e reads the colour calibration file, sent after the header with a checksum.
module fupd_cmd_frame
    import fupd_pkg::*;
#(
    parameter int LEN_W = 32
)
(
    input wire logic core_clk, // 40 MHz clock
    input wire logic reset, // async, active high
    input wire logic rx_valid, // command byte present
    input wire logic [7:0] rx_data, // command byte
    output logic rx_ready, // device takes a byte
    output logic tx_valid, // response byte present
    output logic [7:0] tx_data, // response byte
    input wire logic tx_ready, // host takes a byte
    output logic flash_wr_en, // write one flash byte
    output logic [LEN_W-1:0] flash_addr, // byte index in file
    output logic [7:0] flash_wr_data, // byte to write
    output logic [7:0] flash_target, // selected target code
    output logic flash_commit, // pulse: file complete and good
    output logic flash_abort, // pulse: file written but bad
    output logic flash_rd_en, // read one flash byte
    input wire logic [7:0] flash_rd_data, // read byte, next cycle
    input wire logic [3:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [31:0] reg_rdata, // read data, one cycle later
    output logic irq // level interrupt
);

    // crc-ccitt one byte, msb first
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++)
            c = c[15] ? ((c << 1) ^ `FUPD_CRC16_POLY) : (c << 1);
        return c;
    endfunction

    // crc-32 one byte, msb first, no reflection and no final inversion
    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {d, 24'h000000};
        for (int i = 0; i < 8; i++)
            c = c[31] ? ((c << 1) ^ `FUPD_CRC32_POLY) : (c << 1);
        return c;
    endfunction

    // flash update target codes
    function automatic logic is_update(input logic [7:0] c);
        return (c == `FUPD_CMD_BOOT) || (c == `FUPD_CMD_APP) || (c == `FUPD_CMD_LENS) ||
            (c == `FUPD_CMD_WIGGLE) || (c == `FUPD_CMD_GEOM) ||
            (c == `FUPD_CMD_OVERLAY) || (c == `FUPD_CMD_INTRINSIC);
    endfunction

    // response header byte by offset; target offset and reserved bytes stay zero
    function automatic logic [7:0] resp_byte(input logic [5:0] i, input logic [7:0] cmd,
        input logic [7:0] sub, input logic [7:0] st, input logic [15:0] flg,
        input logic [31:0] len, input logic [31:0] pcrc, input logic [15:0] hcrc);
        logic [511:0] v;
        v = {`FUPD_PREAMBLE, `FUPD_VERSION, cmd, sub, st, flg,
            len, 368'h0, pcrc, hcrc};
        return v[511 - 8 * i -: 8];
    endfunction

    fupd_state_e state_ff;
    logic [5:0] idx_ff; // header byte index, rx or tx
    logic [15:0] hcrc_ff, flags_ff; // running header checksum, flags
    logic [31:0] pcrc_ff, len_ff, pexp_ff; // running sum, declared length, expected sum
    logic [7:0] cmd_ff, sub_ff, hcrc_hi_ff, result_ff;
    logic hdr_bad_ff; // marker or revision mismatch
    logic [LEN_W-1:0] cnt_ff; // payload byte counter
    logic rd_pend_ff, enable_ff; // flash read data due this cycle, control enable
    logic [2:0] irq_stat_ff, irq_mask_ff, ev_set;
    logic [15:0] last_ff; // last command and result
    logic rx_take, tx_take, hdr_last, hdr_ok, pay_last, pay_bad;
    logic [31:0] pcrc_nxt, resp_len, resp_pcrc;
    logic [15:0] hcrc_rx_nxt, hcrc_tx_nxt;

    assign rx_take = rx_valid && rx_ready;
    assign tx_take = tx_valid && tx_ready;
    assign hdr_last = (state_ff == FUPD_S_HDR) && rx_take && (idx_ff == 6'h3f);
    assign pay_last = rx_take && (state_ff == FUPD_S_PAY) && (cnt_ff == LEN_W'(len_ff - 32'h1));
    assign pcrc_nxt = crc32_byte(pcrc_ff, rx_data);
    assign pay_bad = !flags_ff[`FUPD_FLAG_SKIP_PCRC] && (pcrc_nxt != pexp_ff);
    // header checksum covers offsets 2..0x3d only
    assign hcrc_rx_nxt = (idx_ff >= `FUPD_OFS_VERSION && idx_ff <= `FUPD_HCRC_LAST) ?
        crc16_byte(hcrc_ff, rx_data) : hcrc_ff;
    assign hcrc_tx_nxt = (idx_ff >= `FUPD_OFS_VERSION && idx_ff <= `FUPD_HCRC_LAST) ?
        crc16_byte(hcrc_ff, tx_data) : hcrc_ff;
    assign hdr_ok = !hdr_bad_ff && ({hcrc_hi_ff, rx_data} == hcrc_ff);
    // only a colour file read returns a payload
    assign resp_len = (cmd_ff == `FUPD_CMD_RD_COLOR && result_ff == `FUPD_ST_OK) ?
        len_ff : 32'h0;
    assign resp_pcrc = (resp_len != 32'h0) ? pcrc_ff : 32'h0;

    // header receive: field capture, marker and revision checks
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cmd_ff <= 8'h00;
            sub_ff <= 8'h00;
            flags_ff <= 16'h0000;
            len_ff <= 32'h0;
            pexp_ff <= 32'h0;
            hcrc_hi_ff <= 8'h00;
            hdr_bad_ff <= 1'b0;
        end
        else if (state_ff == FUPD_S_HDR && rx_take)
        begin
            unique case (idx_ff)
                6'h00: hdr_bad_ff <= (rx_data != (`FUPD_PREAMBLE >> 8));
                6'h01: hdr_bad_ff <= hdr_bad_ff || (rx_data != (`FUPD_PREAMBLE & 16'h00ff));
                `FUPD_OFS_VERSION: hdr_bad_ff <= hdr_bad_ff || (rx_data != `FUPD_VERSION);
                `FUPD_OFS_CMD: cmd_ff <= rx_data;
                `FUPD_OFS_SUB: sub_ff <= rx_data; // echoed only, never steers
                6'h06: flags_ff[15:8] <= rx_data;
                6'h07: flags_ff[7:0] <= rx_data;
                6'h08, 6'h09, 6'h0a, 6'h0b: len_ff <= {len_ff[23:0], rx_data};
                6'h3a, 6'h3b, 6'h3c, 6'h3d: pexp_ff <= {pexp_ff[23:0], rx_data};
                6'h3e: hcrc_hi_ff <= rx_data;
                default: hdr_bad_ff <= hdr_bad_ff; // 0x0c..0x0f target offset unused
            endcase
        end
    end

    // main sequence: header, payload or flash read, response
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= FUPD_S_HDR;
            idx_ff <= 6'h00;
            hcrc_ff <= `FUPD_CRC16_INIT;
            pcrc_ff <= `FUPD_CRC32_INIT;
            result_ff <= `FUPD_ST_OK;
            cnt_ff <= '0;
            rd_pend_ff <= 1'b0;
            flash_rd_en <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            rx_ready <= 1'b0;
        end
        else
        begin
            flash_rd_en <= 1'b0;
            rd_pend_ff <= flash_rd_en;
            unique case (state_ff)
                FUPD_S_HDR:
                begin
                    rx_ready <= enable_ff;
                    if (rx_take)
                    begin
                        idx_ff <= idx_ff + 6'h1;
                        hcrc_ff <= hcrc_rx_nxt;
                    end
                    if (hdr_last)
                    begin
                        idx_ff <= 6'h00;
                        hcrc_ff <= `FUPD_CRC16_INIT;
                        pcrc_ff <= `FUPD_CRC32_INIT;
                        cnt_ff <= '0;
                        rx_ready <= 1'b0;
                        state_ff <= FUPD_S_RESP;
                        if (!hdr_ok)
                            result_ff <= `FUPD_ST_BAD_HDR;
                        else if (is_update(cmd_ff))
                        begin
                            result_ff <= `FUPD_ST_OK;
                            if (len_ff != 32'h0)
                            begin
                                state_ff <= FUPD_S_PAY;
                                rx_ready <= 1'b1;
                            end
                        end
                        else if (cmd_ff == `FUPD_CMD_RD_COLOR)
                        begin
                            result_ff <= `FUPD_ST_OK;
                            if (len_ff != 32'h0)
                                state_ff <= FUPD_S_RDSUM;
                        end
                        else
                            result_ff <= `FUPD_ST_BAD_CMD;
                    end
                end
                FUPD_S_PAY:
                begin
                    if (rx_take)
                    begin
                        cnt_ff <= cnt_ff + 1'b1;
                        pcrc_ff <= pcrc_nxt;
                    end
                    if (pay_last)
                    begin
                        rx_ready <= 1'b0;
                        state_ff <= FUPD_S_RESP;
                        // a set skip flag bypasses the compare; the bench sets it in one frame
                        if (pay_bad)
                            result_ff <= `FUPD_ST_BAD_PCRC;
                    end
                end
                FUPD_S_RDSUM:
                begin
                    // first pass sums the file so the header can carry its checksum
                    if (rd_pend_ff)
                    begin
                        pcrc_ff <= crc32_byte(pcrc_ff, flash_rd_data);
                        cnt_ff <= cnt_ff + 1'b1;
                        if (cnt_ff == LEN_W'(len_ff - 32'h1))
                            state_ff <= FUPD_S_RESP;
                    end
                    else if (!flash_rd_en)
                        flash_rd_en <= 1'b1;
                end
                FUPD_S_RESP:
                begin
                    if (!tx_valid)
                    begin
                        tx_valid <= 1'b1;
                        tx_data <= resp_byte(6'h00, cmd_ff, sub_ff, result_ff, flags_ff,
                            resp_len, resp_pcrc, hcrc_ff);
                    end
                    else if (tx_take)
                    begin
                        idx_ff <= idx_ff + 6'h1;
                        hcrc_ff <= hcrc_tx_nxt;
                        tx_data <= resp_byte(idx_ff + 6'h1, cmd_ff, sub_ff, result_ff,
                            flags_ff, resp_len, resp_pcrc, hcrc_tx_nxt);
                        if (idx_ff == 6'h3f)
                        begin
                            tx_valid <= 1'b0;
                            idx_ff <= 6'h00;
                            hcrc_ff <= `FUPD_CRC16_INIT;
                            cnt_ff <= '0;
                            state_ff <= (resp_len != 32'h0) ? FUPD_S_RDOUT : FUPD_S_HDR;
                        end
                    end
                end
                FUPD_S_RDOUT:
                begin
                    // second pass streams the file; one byte in flight at a time
                    if (rd_pend_ff)
                    begin
                        tx_valid <= 1'b1;
                        tx_data <= flash_rd_data;
                    end
                    else if (tx_take)
                    begin
                        tx_valid <= 1'b0;
                        cnt_ff <= cnt_ff + 1'b1;
                        if (cnt_ff == LEN_W'(len_ff - 32'h1))
                            state_ff <= FUPD_S_HDR;
                    end
                    else if (!tx_valid && !flash_rd_en)
                        flash_rd_en <= 1'b1;
                end
                default: state_ff <= FUPD_S_HDR;
            endcase
        end
    end

    // flash write port: payload bytes go out only after a good header
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            flash_wr_en <= 1'b0;
            flash_wr_data <= 8'h00;
            flash_addr <= '0;
            flash_target <= 8'h00;
            flash_commit <= 1'b0;
            flash_abort <= 1'b0;
        end
        else
        begin
            flash_wr_en <= (state_ff == FUPD_S_PAY) && rx_take;
            flash_wr_data <= rx_data;
            // a length-0 update commits at once; otherwise the last payload byte decides
            flash_commit <= (hdr_last && hdr_ok && is_update(cmd_ff) && len_ff == 32'h0) ||
                (pay_last && !pay_bad);
            flash_abort <= pay_last && pay_bad;
            if (state_ff == FUPD_S_PAY || state_ff == FUPD_S_RDSUM || state_ff == FUPD_S_RDOUT)
                flash_addr <= cnt_ff; // file offset, never the header offset field
            if (hdr_last && hdr_ok)
                flash_target <= cmd_ff;
        end
    end

    // interrupt events; a set in the clearing cycle wins
    assign ev_set[`FUPD_IRQ_DONE] = (state_ff == FUPD_S_RESP) && tx_take && (idx_ff == 6'h3f);
    assign ev_set[`FUPD_IRQ_HDR_ERR] = hdr_last && !hdr_ok;
    assign ev_set[`FUPD_IRQ_PCRC_ERR] = pay_last && pay_bad;

    // register writes: status w1c, mask, control
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            enable_ff <= `FUPD_CTRL_RESET;
        end
        else
        begin
            if (reg_wr && reg_addr == `FUPD_REG_IRQ_STATUS)
                irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | ev_set;
            else
                irq_stat_ff <= irq_stat_ff | ev_set;
            if (reg_wr && reg_addr == `FUPD_REG_IRQ_MASK)
                irq_mask_ff <= reg_wdata[2:0];
            if (reg_wr && reg_addr == `FUPD_REG_CTRL)
                enable_ff <= reg_wdata[0];
        end
    end

    // register reads, last result capture and interrupt output
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= 32'h0;
            last_ff <= 16'h0000;
            irq <= 1'b0;
        end
        else
        begin
            irq <= |((irq_stat_ff | ev_set) & irq_mask_ff);
            if (ev_set[`FUPD_IRQ_DONE])
                last_ff <= {cmd_ff, result_ff};
            reg_rdata <= 32'h0;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    `FUPD_REG_IRQ_STATUS: reg_rdata <= {29'h0, irq_stat_ff};
                    `FUPD_REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_ff};
                    `FUPD_REG_CTRL: reg_rdata <= {31'h0, enable_ff};
                    `FUPD_REG_LAST: reg_rdata <= {16'h0, last_ff};
                    default: reg_rdata <= 32'h0;
                endcase
            end
        end
    end

endmodule

// ==== fupd_params.svh ====
// offsets, field positions, codes and reset values of the flash update frame handler
// assumes byte offsets within a 64-byte header, most significant byte first
`ifndef FUPD_PARAMS_SVH
`define FUPD_PARAMS_SVH
`define FUPD_HDR_LEN 7'h40
`define FUPD_PREAMBLE 16'ha1ec
`define FUPD_VERSION 8'h03
`define FUPD_OFS_VERSION 6'h02
`define FUPD_OFS_CMD 6'h03
`define FUPD_OFS_SUB 6'h04
`define FUPD_OFS_STATUS 6'h05
`define FUPD_OFS_FLAGS 6'h06
`define FUPD_OFS_LEN 6'h08
`define FUPD_OFS_PCRC 6'h3a
`define FUPD_OFS_HCRC 6'h3e
`define FUPD_HCRC_LAST 6'h3d
`define FUPD_FLAG_SKIP_PCRC 0
`define FUPD_CRC16_POLY 16'h1021
`define FUPD_CRC16_INIT 16'h0000
`define FUPD_CRC32_POLY 32'h04c11db7
`define FUPD_CRC32_INIT 32'h0fffffff
`define FUPD_CMD_BOOT 8'h0b
`define FUPD_CMD_APP 8'h0c
`define FUPD_CMD_LENS 8'h15
`define FUPD_CMD_WIGGLE 8'h16
`define FUPD_CMD_GEOM 8'h18
`define FUPD_CMD_OVERLAY 8'h19
`define FUPD_CMD_INTRINSIC 8'h29
`define FUPD_CMD_RD_COLOR 8'h8e
`define FUPD_ST_OK 8'h00
`define FUPD_ST_BAD_HDR 8'h01
`define FUPD_ST_BAD_CMD 8'h02
`define FUPD_ST_BAD_PCRC 8'h03
`define FUPD_REG_IRQ_STATUS 4'h0
`define FUPD_REG_IRQ_MASK 4'h4
`define FUPD_REG_CTRL 4'h8
`define FUPD_REG_LAST 4'hc
`define FUPD_IRQ_DONE 0
`define FUPD_IRQ_HDR_ERR 1
`define FUPD_IRQ_PCRC_ERR 2
`define FUPD_CTRL_RESET 1'b1
`endif

// ==== fupd_pkg.sv ====
// types shared by the flash update frame handler
// assumes fupd_params.svh holds all numeric constants
package fupd_pkg;
    typedef enum logic [4:0]
    {
        FUPD_S_HDR = 5'b00001,
        FUPD_S_PAY = 5'b00010,
        FUPD_S_RDSUM = 5'b00100,
        FUPD_S_RESP = 5'b01000,
        FUPD_S_RDOUT = 5'b10000
    } fupd_state_e;
endpackage

// ==== fupd_cmd_frame_props.sv ====
// port-level assertions for the flash update frame handler
// assumes one clock domain, core_clk, and reset async active high
`timescale 1ns/1ps
module fupd_cmd_frame_props
(
    input wire logic core_clk, // clock
    input wire logic reset, // async reset
    input wire logic rx_valid, // byte offered
    input wire logic [7:0] rx_data, // command byte
    input wire logic rx_ready, // byte taken
    input wire logic tx_valid, // response byte offered
    input wire logic [7:0] tx_data, // response byte
    input wire logic tx_ready, // host takes
    input wire logic flash_wr_en, // write pulse
    input wire logic [7:0] flash_wr_data, // written byte
    input wire logic [7:0] flash_target, // target code
    input wire logic flash_commit, // good file
    input wire logic flash_abort, // bad file
    input wire logic flash_rd_en, // read pulse
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata // read data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // a flash pass ends in one verdict, then the response opens with the marker
    sequence s_file_end;
        flash_commit || flash_abort;
    endsequence
    sequence s_resp_open;
        tx_valid && tx_data == 8'ha1;
    endsequence
    AST_RESP_AFTER_FILE: assert property (s_file_end |=> s_resp_open)
        else $error("response did not open after the flash pass");
    AST_ONE_VERDICT: assert property (s_file_end |-> !(flash_commit && flash_abort))
        else $error("commit and abort together");
    AST_WR_FROM_TAKE: assert property (flash_wr_en |-> $past(rx_valid && rx_ready)
        && flash_wr_data == $past(rx_data))
        else $error("flash write without a matching payload take");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte changed before it was taken");
    AST_NO_TAKE_IN_RESP: assert property (tx_valid |-> !rx_ready)
        else $error("command bytes taken while responding");
    AST_RD_SPACED: assert property (flash_rd_en |=> !flash_rd_en)
        else $error("flash reads back to back");
    AST_TARGET_HELD: assert property (flash_wr_en |-> $stable(flash_target))
        else $error("target changed during payload");
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule
bind fupd_cmd_frame fupd_cmd_frame_props fupd_cmd_frame_props_i (.core_clk(core_clk),
    .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .flash_wr_en(flash_wr_en),
    .flash_wr_data(flash_wr_data), .flash_target(flash_target), .flash_commit(flash_commit),
    .flash_abort(flash_abort), .flash_rd_en(flash_rd_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ==== fupd_host_model.sv ====
// host side model: streams queued command bytes and collects response bytes
// assumes the bench fills sendq and empties got by hierarchical reference
`timescale 1ns/1ps
module fupd_host_model
(
    input wire logic core_clk, // device clock
    input wire logic reset, // active high
    input wire logic slow, // drop tx_ready on every other cycle
    output logic rx_valid, // command byte offered
    output logic [7:0] rx_data, // command byte
    input wire logic rx_ready, // device takes byte
    input wire logic tx_valid, // response byte offered
    input wire logic [7:0] tx_data, // response byte
    output logic tx_ready // host takes byte
);
    logic [7:0] sendq[$];
    logic [7:0] got[$];
    // bytes held until taken; idle data inverts so a stale byte never looks valid
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            tx_ready <= 1'b0;
        end
        else
        begin
            if (rx_valid && rx_ready)
                sendq.delete(0);
            rx_valid <= sendq.size() != 0;
            rx_data <= sendq.size() != 0 ? sendq[0] : ~rx_data;
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready)
                got.push_back(tx_data);
        end
    end
endmodule

// ==== flash_update_command_frames_tb_top.sv ====
// self-checking bench for the flash update frame handler
// assumes the host model streams frames and a flash stub answers reads
`timescale 1ns/1ps
`include "fupd_params.svh"
module flash_update_command_frames_tb_top;
    localparam int N = 3; // payload bytes per update frame
    logic core_clk, reset, slow, rx_valid, rx_ready, tx_valid, tx_ready, irq;
    logic flash_wr_en, flash_commit, flash_abort, flash_rd_en, reg_wr, reg_rd;
    logic [7:0] rx_data, tx_data, flash_wr_data, flash_target, flash_rd_data;
    logic [31:0] flash_addr, reg_wdata, reg_rdata;
    logic [3:0] reg_addr;
    int miscompares, comparisons, cyc, nwr, ncm, nab;
    // {command, fault kind, flags low byte, expected result}
    logic [31:0] rows[14] = '{32'h0b000000, 32'h0c000000, 32'h15000000, 32'h16000000,
        32'h18000000, 32'h19000000, 32'h29000000, 32'h8e000000, 32'h07000002, 32'h0b010001,
        32'h0b020001, 32'h0c030001, 32'h15040003, 32'h16040100};
    fupd_cmd_frame #(.LEN_W(32)) fupd_cmd_frame_i (.core_clk(core_clk), .reset(reset),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .flash_wr_en(flash_wr_en),
        .flash_addr(flash_addr), .flash_wr_data(flash_wr_data), .flash_target(flash_target),
        .flash_commit(flash_commit), .flash_abort(flash_abort), .flash_rd_en(flash_rd_en),
        .flash_rd_data(flash_rd_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    fupd_host_model fupd_host_model_i (.core_clk(core_clk), .reset(reset), .slow(slow),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    // 40 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // event counts, cycle ceiling, flash stub answering one cycle after the address
    always @(posedge core_clk)
    begin
        cyc += 1;
        nwr += flash_wr_en;
        ncm += flash_commit;
        nab += flash_abort;
        flash_rd_data <= flash_addr[7:0] ^ 8'h5a;
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "register");
    endtask
    function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] b);
        c ^= {b, 24'h0};
        repeat (8) c = c[31] ? (c << 1) ^ `FUPD_CRC32_POLY : c << 1;
        return c;
    endfunction
    // header checksum over bytes 2 to 0x3d, high bit first from zero
    function automatic logic [15:0] hcrc(input logic [511:0] v);
        logic [15:0] c;
        c = `FUPD_CRC16_INIT;
        for (int i = 2; i < 62; i++)
        begin
            c ^= {v[511 - 8 * i -: 8], 8'h00};
            repeat (8) c = c[15] ? (c << 1) ^ `FUPD_CRC16_POLY : c << 1;
        end
        return c;
    endfunction
    // one frame: build, stream, then compare the response and the flash activity
    task automatic run(input logic [31:0] r);
        logic [511:0] hv;
        logic [511:0] ev;
        logic [31:0] pc;
        logic [31:0] fc;
        logic [7:0] cmd;
        int nx;
        int good;
        cmd = r[31:24];
        nx = (cmd == `FUPD_CMD_RD_COLOR) ? N : 0;
        good = (r[7:0] == 8'h00 || r[7:0] == 8'h03) && nx == 0;
        pc = `FUPD_CRC32_INIT;
        fc = `FUPD_CRC32_INIT;
        for (int i = 0; i < N; i++)
        begin
            pc = c32(pc, 8'(i * 3 + 1));
            fc = c32(fc, 8'(i) ^ 8'h5a);
        end
        // sub and target offset carry filler the device must not act on
        hv = {`FUPD_PREAMBLE, 8'h03, cmd, 8'h55, 8'h00, 8'h00, r[15:8], 32'(N), 32'h77777777,
            336'h0, pc ^ 32'(r[23:16] == 8'h04), 16'h0};
        if (r[23:16] == 8'h02)
            hv[495 -: 8] = 8'h02;
        hv[15:0] = hcrc(hv) ^ 16'(r[23:16] == 8'h03);
        if (r[23:16] == 8'h01)
            hv[511 -: 8] = 8'ha0;
        #1;
        nwr = 0;
        ncm = 0;
        nab = 0;
        for (int i = 0; i < 64; i++)
            fupd_host_model_i.sendq.push_back(hv[511 - 8 * i -: 8]);
        for (int i = 0; i < N && good; i++)
            fupd_host_model_i.sendq.push_back(8'(i * 3 + 1));
        for (int k = 0; k < 3000 && fupd_host_model_i.got.size() < 64 + nx; k++)
            @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        ev = {`FUPD_PREAMBLE, 8'h03, cmd, 8'h55, r[7:0], 8'h00, r[15:8], 32'(nx), 368'h0,
            nx ? fc : 32'h0, 16'h0};
        ev[15:0] = hcrc(ev);
        chk(fupd_host_model_i.got.size(), 64 + nx, "resp_size");
        for (int i = 0; i < 64 + nx && i < fupd_host_model_i.got.size(); i++)
            chk(fupd_host_model_i.got[i], i < 64 ? ev[511 - 8 * i -: 8]
                : 8'(i - 64) ^ 8'h5a, "resp_byte");
        chk(nwr, good ? N : 0, "flash_writes");
        chk(ncm, good && r[7:0] == 8'h00, "commit");
        chk(nab, r[7:0] == 8'h03, "abort");
        if (good)
            chk(flash_target, cmd, "target");
        fupd_host_model_i.got.delete();
        $display("frame test %h done", r);
    endtask
    // reset values, frame table, then interrupt, enable and last-result checks
    initial
    begin
        reset = 1'b1;
        slow = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        flash_rd_data = 8'h00;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h1);
        rd(4'h2, 32'h0);
        $display("register reset test done");
        for (int i = 0; i < 14; i++)
        begin
            slow <= i[0];
            run(rows[i]);
            if (i == 0)
            begin
                chk(irq, 1'b0, "irq_masked");
                wr(4'h4, 32'h7);
            end
        end
        chk(irq, 1'b1, "irq_raised");
        rd(4'h0, 32'h7);
        wr(4'h0, 32'h7);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0, "irq_cleared");
        wr(4'h8, 32'h0);
        repeat (2) @(posedge core_clk);
        chk(rx_ready, 1'b0, "disabled");
        wr(4'h8, 32'h1);
        run(rows[0]);
        rd(4'hc, 32'h0b00);
        $display("register and interrupt test done");
        final_report();
    end
endmodule
